// file: tcc_pkg.sv
// Purpose: Shared constants and types for the timer 3/4 control block.
// Assumes: Byte-wide register port, one 25 MHz clock.
// Notes: Offsets are byte addresses on the plain register port.
package tcc_pkg;
    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam logic [7:0] OFS_TIMER3_CONTROL = 8'h18;
    localparam logic [7:0] OFS_TIMER4_CONTROL = 8'h19;
    localparam logic [7:0] OFS_TIMER3_COMPARE = 8'h1a;
    localparam logic [7:0] OFS_TIMER3_PWIDTH = 8'h1b;
    localparam logic [7:0] OFS_TIMER4_COMPARE = 8'h1c;
    localparam logic [7:0] OFS_TIMER4_PWIDTH = 8'h1d;
    localparam logic [7:0] OFS_TIMER3_COUNT = 8'h1e;
    localparam logic [7:0] OFS_TIMER4_COUNT = 8'h1f;
    localparam logic [7:0] OFS_CLOCK_CONFIG = 8'h20;

    // ********************************************************************
    // Control and clock config register fields and reset values
    // ********************************************************************
    localparam int POS_PRESET = 7;
    localparam int POS_CLKSEL_HI = 6;
    localparam int POS_CLKSEL_LO = 4;
    localparam int POS_RUN = 3;
    localparam int POS_MODE_HI = 2;
    localparam int POS_MODE_LO = 0;
    localparam int POS_DIV_OPTION = 0;
    localparam int POS_LOW_SPEED = 1;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_CONFIG = 8'h00;

    // ********************************************************************
    // Prescaler widths
    // ********************************************************************
    localparam int FAST_DIV_BITS = 11;
    localparam int SLOW_DIV_BITS = 3;

    // Clock select codes.
    typedef enum logic [2:0] {
        CK_FAST_2048 = 3'h0,
        CK_FAST_128 = 3'h1,
        CK_FAST_32 = 3'h2,
        CK_FAST_8 = 3'h3,
        CK_SLOW = 3'h4,
        CK_FAST_2 = 3'h5,
        CK_FAST = 3'h6,
        CK_EXT_PIN = 3'h7
    } tcc_clksel_t;

    // Operating mode codes.
    typedef enum logic [2:0] {
        MD_TIMER8 = 3'h0,
        MD_PDO8 = 3'h1,
        MD_PWM8 = 3'h2,
        MD_CASCADE = 3'h3,
        MD_TIMER16 = 3'h4,
        MD_WARMUP = 3'h5,
        MD_PWM16 = 3'h6,
        MD_PPG16 = 3'h7
    } tcc_mode_t;
endpackage

// file: tcc_prescaler.sv
// Purpose: Fast and slow clock prescaler giving one-cycle tick enables.
// Assumes: Slow clock pin is already synchronised to CLK.
// Notes: Ticks are single cycles of CLK.
`timescale 1ns/1ns
module tcc_prescaler
    import tcc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow_level,
    output logic tick_fast_2,
    output logic tick_fast_8,
    output logic tick_fast_32,
    output logic tick_fast_128,
    output logic tick_fast_2048,
    output logic tick_slow,
    output logic tick_slow_8
);
    logic [FAST_DIV_BITS-1:0] fast_cnt_q, fast_cnt_d;
    logic [SLOW_DIV_BITS-1:0] slow_cnt_q, slow_cnt_d;
    logic slow_prev_q, slow_prev_d;

    // Free-running dividers; the slow one advances on slow clock rising edges.
    always_comb begin
        fast_cnt_d = fast_cnt_q + 1'b1;
        slow_prev_d = slow_level;
        slow_cnt_d = tick_slow ? slow_cnt_q + 1'b1 : slow_cnt_q;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fast_cnt_q <= '0;
            slow_cnt_q <= '0;
            slow_prev_q <= 1'b0;
        end else begin
            fast_cnt_q <= fast_cnt_d;
            slow_cnt_q <= slow_cnt_d;
            slow_prev_q <= slow_prev_d;
        end
    end

    // A divided tick fires when the low bits of its divider are all ones; tick_slow fires on a slow clock rising edge.
    assign tick_fast_2 = fast_cnt_q[0];
    assign tick_fast_8 = &fast_cnt_q[2:0];
    assign tick_fast_32 = &fast_cnt_q[4:0];
    assign tick_fast_128 = &fast_cnt_q[6:0];
    assign tick_fast_2048 = &fast_cnt_q;
    assign tick_slow = slow_level & ~slow_prev_q;
    assign tick_slow_8 = tick_slow & (&slow_cnt_q);
endmodule // tcc_prescaler

// file: tcc_timer34.sv
// Purpose: Control of timer 3 and its cascade into timer 4.
// Assumes: Register port strobes from CLK logic; pins are asynchronous.
// Notes: Counters are minimal up counters giving ticks and overflow.
// Function
// - Timer 3 control is 8 bits: preset, clock select, run, mode; resets zero.
// - Clock select picks fast divisions, slow clock, or external pin.
// - Low-speed modes allow only slow sources, pin, or fast clock for warm-up.
// - Mode field: timer, divider output, 8-bit PWM, cascade; top bit reserved.
// - Mode 011 joins both counters; timer 4 mode picks the 16-bit function.
// - Cascade uses timer 3 clock select but timer 4 run and preset.
// - Run 0 stops and clears; run 1 starts; stop write keeps fields.
// - Timer 3 pulse width may change live only in PWM modes.
// - Timer 4 pulse width may change live only in PWM modes.
// - Timer 4 mode: 100 timer16, 101 warm-up, 110 PWM16, 111 PPG16.
// - Timer 4 upper-byte modes count timer 3 overflow, ignoring own select.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
module tcc_timer34
    import tcc_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic SLOW_CLK_PIN,
    input wire logic EXT_COUNT3_PIN,
    input wire logic EXT_COUNT4_PIN,
    output logic TIMER3_RUNNING,
    output logic TIMER4_RUNNING,
    output logic TIMER3_FF,
    output logic TIMER4_FF,
    output logic CASCADE_16BIT,
    output logic TIMER3_OVERFLOW,
    output logic TIMER4_OVERFLOW
);
    import tcc_pkg::*;

    // ********************************************************************
    // Pin synchronisers
    // ********************************************************************
    logic [2:0] sync1_q, sync2_q;
    logic ext3_prev_q, ext4_prev_q;

    // Two flops per pin; only the second stage is used by logic.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sync1_q <= '0;
            sync2_q <= '0;
            ext3_prev_q <= 1'b0;
            ext4_prev_q <= 1'b0;
        end else begin
            sync1_q <= {EXT_COUNT4_PIN, EXT_COUNT3_PIN, SLOW_CLK_PIN};
            sync2_q <= sync1_q;
            ext3_prev_q <= sync2_q[1];
            ext4_prev_q <= sync2_q[2];
        end
    end

    logic ext3_tick, ext4_tick;
    assign ext3_tick = sync2_q[1] & ~ext3_prev_q;
    assign ext4_tick = sync2_q[2] & ~ext4_prev_q;

    logic t_f2, t_f8, t_f32, t_f128, t_f2048, t_slow, t_slow8;

    // Prescaler for all internal source clocks.
    tcc_prescaler u_prescaler (
        .clk(CLK),
        .rst_n(RST_N),
        .slow_level(sync2_q[0]),
        .tick_fast_2(t_f2),
        .tick_fast_8(t_f8),
        .tick_fast_32(t_f32),
        .tick_fast_128(t_f128),
        .tick_fast_2048(t_f2048),
        .tick_slow(t_slow),
        .tick_slow_8(t_slow8)
    );

    // ********************************************************************
    // Registers
    // ********************************************************************
    logic [7:0] ctl3_q, ctl3_d, ctl4_q, ctl4_d;
    logic [7:0] cmp3_q, cmp3_d, pw3_q, pw3_d, cmp4_q, cmp4_d, pw4_q, pw4_d;
    logic [7:0] cfg_q, cfg_d, rdata_q, rdata_d;
    logic [7:0] cnt3_q, cnt3_d, cnt4_q, cnt4_d;
    logic ff3_q, ff3_d, ff4_q, ff4_d;

    logic cascade, run3, run4, low_speed, div_opt, warmup;
    logic tick3, tick4, ovf3, ovf4;

    assign low_speed = cfg_q[POS_LOW_SPEED];
    assign div_opt = cfg_q[POS_DIV_OPTION];
    assign cascade = (ctl3_q[POS_MODE_HI:POS_MODE_LO] == MD_CASCADE);
    assign warmup = cascade && (ctl4_q[POS_MODE_HI:POS_MODE_LO] == MD_WARMUP);
    // In cascade the pair follows the timer 4 run bit.
    assign run3 = cascade ? ctl4_q[POS_RUN] : ctl3_q[POS_RUN];
    assign run4 = ctl4_q[POS_RUN];

    // Tests whether a mode lets its pulse width register change live.
    function automatic logic pwm_mode(input logic [2:0] m3, input logic [2:0] m4);
        pwm_mode = (m3 == MD_PWM8) || (m3 == MD_CASCADE && m4 == MD_PWM16);
    endfunction

    // Picks the count tick for a clock select code and power state.
    function automatic logic pick_tick(input logic [2:0] sel, input logic ext, input logic wu);
        logic t;
        t = 1'b0;
        case (sel)
            CK_FAST_2048: t = (div_opt || low_speed) ? t_slow8 : t_f2048;
            CK_FAST_128: t = !low_speed && t_f128;
            CK_FAST_32: t = !low_speed && t_f32;
            CK_FAST_8: t = !low_speed && t_f8;
            CK_SLOW: t = t_slow;
            CK_FAST_2: t = !low_speed && t_f2;
            CK_FAST: t = !low_speed || wu;
            CK_EXT_PIN: t = ext;
            default: t = 1'b0;
        endcase
        pick_tick = t;
    endfunction

    // Timer 3 uses its own select; timer 4 counts overflow in upper-byte modes.
    // A process is used because the tick picker reads prescaler ticks that are not its arguments.
    always_comb begin
        tick3 = run3 && pick_tick(ctl3_q[POS_CLKSEL_HI:POS_CLKSEL_LO], ext3_tick, warmup);
        tick4 = run4 && (ctl4_q[POS_MODE_HI] ? ovf3 :
                pick_tick(ctl4_q[POS_CLKSEL_HI:POS_CLKSEL_LO], ext4_tick, 1'b0));
    end
    // In cascade timer 3 is the low byte and wraps at full scale.
    assign ovf3 = tick3 && (cascade ? (cnt3_q == 8'hff) : (cnt3_q == cmp3_q));
    assign ovf4 = tick4 && (cnt4_q == cmp4_q);

    logic wr3, wr4, start3, stop3, start4, stop4;
    assign wr3 = WR && (ADDR == OFS_TIMER3_CONTROL);
    assign wr4 = WR && (ADDR == OFS_TIMER4_CONTROL);
    assign start3 = wr3 && WDATA[POS_RUN] && !ctl3_q[POS_RUN];
    assign stop3 = wr3 && !WDATA[POS_RUN] && ctl3_q[POS_RUN];
    assign start4 = wr4 && WDATA[POS_RUN] && !ctl4_q[POS_RUN];
    assign stop4 = wr4 && !WDATA[POS_RUN] && ctl4_q[POS_RUN];

    // ********************************************************************
    // Register write and counting
    // ********************************************************************
    always_comb begin
        ctl3_d = ctl3_q;
        ctl4_d = ctl4_q;
        cmp3_d = cmp3_q;
        pw3_d = pw3_q;
        cmp4_d = cmp4_q;
        pw4_d = pw4_q;
        cfg_d = cfg_q;
        // A stop write only drops the run bit; other fields are kept.
        if (wr3) begin
            ctl3_d = ctl3_q[POS_RUN] ? {ctl3_q[7:4], WDATA[POS_RUN], ctl3_q[2:0]} : WDATA;
        end
        if (wr4) begin
            ctl4_d = ctl4_q[POS_RUN] ? {ctl4_q[7:4], WDATA[POS_RUN], ctl4_q[2:0]} : WDATA;
        end
        // Compare registers load only while stopped.
        if (WR && ADDR == OFS_TIMER3_COMPARE && !run3) begin
            cmp3_d = WDATA;
        end
        if (WR && ADDR == OFS_TIMER4_COMPARE && !run4) begin
            cmp4_d = WDATA;
        end
        // Pulse width registers load live only in PWM modes.
        if (WR && ADDR == OFS_TIMER3_PWIDTH &&
            (!run3 || pwm_mode(ctl3_q[2:0], ctl4_q[2:0]))) begin
            pw3_d = WDATA;
        end
        if (WR && ADDR == OFS_TIMER4_PWIDTH &&
            (!run4 || pwm_mode(ctl3_q[2:0], ctl4_q[2:0]))) begin
            pw4_d = WDATA;
        end
        if (WR && ADDR == OFS_CLOCK_CONFIG) begin
            cfg_d = {6'h00, WDATA[1:0]};
        end
    end

    // Counters clear when stopped; flip-flops take the preset at start, timer 3's only outside cascade.
    always_comb begin
        cnt3_d = cnt3_q;
        cnt4_d = cnt4_q;
        ff3_d = ff3_q;
        ff4_d = ff4_q;
        if (!run3 || stop3 || (cascade && stop4)) begin
            cnt3_d = 8'h00;
        end else if (tick3) begin
            cnt3_d = ovf3 ? 8'h00 : cnt3_q + 8'h01;
        end
        if (!run4 || stop4) begin
            cnt4_d = 8'h00;
        end else if (tick4) begin
            cnt4_d = ovf4 ? 8'h00 : cnt4_q + 8'h01;
        end else begin
            cnt4_d = cnt4_q;
        end
        if (start3 && !cascade) begin
            ff3_d = WDATA[POS_PRESET];
        end else if (ovf3 && !cascade) begin
            ff3_d = ~ff3_q;
        end
        if (start4) begin
            ff4_d = WDATA[POS_PRESET];
        end else if (ovf4) begin
            ff4_d = ~ff4_q;
        end
    end

    // Read data returns in the cycle after the read strobe.
    always_comb begin
        rdata_d = 8'h00;
        if (RD) begin
            case (ADDR)
                OFS_TIMER3_CONTROL: rdata_d = ctl3_q;
                OFS_TIMER4_CONTROL: rdata_d = ctl4_q;
                OFS_TIMER3_COMPARE: rdata_d = cmp3_q;
                OFS_TIMER3_PWIDTH: rdata_d = pw3_q;
                OFS_TIMER4_COMPARE: rdata_d = cmp4_q;
                OFS_TIMER4_PWIDTH: rdata_d = pw4_q;
                OFS_TIMER3_COUNT: rdata_d = cnt3_q;
                OFS_TIMER4_COUNT: rdata_d = cnt4_q;
                OFS_CLOCK_CONFIG: rdata_d = cfg_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ctl3_q <= RST_CONTROL;
            ctl4_q <= RST_CONTROL;
            cmp3_q <= RST_DATA;
            pw3_q <= RST_DATA;
            cmp4_q <= RST_DATA;
            pw4_q <= RST_DATA;
            cfg_q <= RST_CONFIG;
            rdata_q <= RST_DATA;
            cnt3_q <= RST_DATA;
            cnt4_q <= RST_DATA;
            ff3_q <= 1'b0;
            ff4_q <= 1'b0;
        end else begin
            ctl3_q <= ctl3_d;
            ctl4_q <= ctl4_d;
            cmp3_q <= cmp3_d;
            pw3_q <= pw3_d;
            cmp4_q <= cmp4_d;
            pw4_q <= pw4_d;
            cfg_q <= cfg_d;
            rdata_q <= rdata_d;
            cnt3_q <= cnt3_d;
            cnt4_q <= cnt4_d;
            ff3_q <= ff3_d;
            ff4_q <= ff4_d;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    assign RDATA = rdata_q;
    assign TIMER3_RUNNING = run3;
    assign TIMER4_RUNNING = run4;
    assign TIMER3_FF = ff3_q;
    assign TIMER4_FF = ff4_q;
    assign CASCADE_16BIT = cascade;
    assign TIMER3_OVERFLOW = ovf3;
    assign TIMER4_OVERFLOW = ovf4;
endmodule // tcc_timer34

// file: tcc_timer34_props.sv
// Purpose: Port assertions for the timer 3/4 control block.
// Assumes: One clock, synchronous active-low reset, plain register port.
// Notes: Bound to tcc_timer34 after the module.
`timescale 1ns/1ns
module tcc_timer34_props
    import tcc_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic TIMER3_RUNNING,
    input wire logic TIMER4_RUNNING,
    input wire logic TIMER3_FF,
    input wire logic CASCADE_16BIT,
    input wire logic TIMER3_OVERFLOW
);
    // ********************************************************************
    // Read data and control register checks
    // ********************************************************************
    default clocking dc @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    // A write to the timer 3 control register.
    sequence s_ctl3_wr;
        WR && ADDR == OFS_TIMER3_CONTROL;
    endsequence
    // Both timers idle, so every field of the write is taken unless the timer 3 run bit is still set in cascade.
    sequence s_idle;
        !TIMER3_RUNNING && !TIMER4_RUNNING;
    endsequence

    rd_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data not zero outside a read answer");
    rd_unmapped_a: assert property (RD && ADDR > OFS_CLOCK_CONFIG |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
    start_preset_a: assert property (s_ctl3_wr ##0 s_idle ##0 (WDATA[3] && WDATA[2:0] != 3'h3)
        |=> TIMER3_RUNNING && TIMER3_FF == $past(WDATA[7])) else $error("start did not load preset");
    stop_clear_a: assert property (s_ctl3_wr ##0 (!WDATA[3] && !CASCADE_16BIT && WDATA[2:0] != 3'h3)
        |=> !TIMER3_RUNNING) else $error("stop write left timer running");
    mode_accept_a: assert property (s_ctl3_wr ##0 s_idle ##0 !WDATA[3]
        |=> CASCADE_16BIT == ($past(WDATA[2:0]) == 3'h3)) else $error("cascade flag wrong");
    run_lock_a: assert property (s_ctl3_wr ##0 (TIMER3_RUNNING && !CASCADE_16BIT) |=> !CASCADE_16BIT)
        else $error("mode changed while running");
    cascade_run_a: assert property (CASCADE_16BIT |-> TIMER3_RUNNING == TIMER4_RUNNING)
        else $error("cascade run does not follow timer 4");
    ovf_stopped_a: assert property (!TIMER3_RUNNING |-> !TIMER3_OVERFLOW)
        else $error("overflow while stopped");
    ff_hold_a: assert property (!TIMER3_RUNNING && !CASCADE_16BIT && !(WR && ADDR == OFS_TIMER3_CONTROL)
        |=> $stable(TIMER3_FF)) else $error("flip-flop moved while stopped");
endmodule // tcc_timer34_props

bind tcc_timer34 tcc_timer34_props props_i (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .TIMER3_RUNNING(TIMER3_RUNNING), .TIMER4_RUNNING(TIMER4_RUNNING),
    .TIMER3_FF(TIMER3_FF), .CASCADE_16BIT(CASCADE_16BIT), .TIMER3_OVERFLOW(TIMER3_OVERFLOW));

// file: timer3_control_and_cascade_bench.sv
// Purpose: Self-checking bench for the timer 3/4 control block.
// Assumes: Register reads answer one cycle after the read strobe.
// Notes: Pins toggle at random; exact counts are not checked.
`timescale 1ns/1ns
module timer3_control_and_cascade_bench;
    import tcc_pkg::*;
    // ********************************************************************
    // Stimulus and checking
    // ********************************************************************
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic slow_pin = 1'b0;
    logic ext3 = 1'b0;
    logic ext4 = 1'b0;
    logic [7:0] rdata;
    logic t3_run, t4_run, t3_ff, t4_ff, casc, t3_ovf, t4_ovf;
    logic rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] v;
    logic p;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;

    tcc_timer34 DUT (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr_en), .RD(rd_en),
        .RDATA(rdata), .SLOW_CLK_PIN(slow_pin), .EXT_COUNT3_PIN(ext3), .EXT_COUNT4_PIN(ext4),
        .TIMER3_RUNNING(t3_run), .TIMER4_RUNNING(t4_run), .TIMER3_FF(t3_ff), .TIMER4_FF(t4_ff),
        .CASCADE_16BIT(casc), .TIMER3_OVERFLOW(t3_ovf), .TIMER4_OVERFLOW(t4_ovf));

    // Clock of 40 ns period.
    always #20 clk = ~clk;

    // Random pin activity and a cycle ceiling against hangs.
    always @(posedge clk) begin
        slow_pin <= 1'($urandom);
        ext3 <= 1'($urandom);
        ext4 <= 1'($urandom);
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Read answers are taken off the queue in the cycle after the strobe.
    always @(posedge clk) rd_seen <= rd_en;
    always @(negedge clk) begin
        if (rd_seen) check(rdata, exp_q.pop_front());
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(posedge clk);
    endtask

    // Checks the run and cascade levels once the edge has settled.
    task automatic lvl(input logic [1:0] e);
        #1;
        check({6'h00, t3_run, casc}, {6'h00, e});
    endtask

    task automatic wait_ovf(input bit sel, input int lim, input logic e);
        int n;
        n = 0;
        while (n < lim && (sel ? t4_ovf : t3_ovf) !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
        end
        check({7'h00, n < lim}, {7'h00, e});
    endtask

    // Main sequence.
    initial begin
        void'($urandom(32'hcc57c6a6));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int a = 8'h18; a <= 8'h20; a++) rd(a[7:0], 8'h00);
        rd(8'h40, 8'h00);
        wr(OFS_TIMER3_COMPARE, 8'hff);
        for (int c = 0; c < 8; c++) begin
            p = 1'($urandom);
            v = {p, c[2:0], 4'hc};
            wr(OFS_TIMER3_CONTROL, v);
            lvl(2'b10);
            check({7'h00, t3_ff}, {7'h00, p});
            rd(OFS_TIMER3_CONTROL, v);
            wr(OFS_TIMER3_CONTROL, ~v | 8'h08);
            rd(OFS_TIMER3_CONTROL, v);
            wr(OFS_TIMER3_COMPARE, 8'h11);
            rd(OFS_TIMER3_COMPARE, 8'hff);
            wr(OFS_TIMER3_PWIDTH, 8'h22);
            rd(OFS_TIMER3_PWIDTH, 8'h00);
            wr(OFS_TIMER3_CONTROL, ~v & 8'hf7);
            rd(OFS_TIMER3_CONTROL, v & 8'hf7);
            rd(OFS_TIMER3_COUNT, 8'h00);
        end
        for (int m = 0; m < 8; m++) begin
            wr(OFS_TIMER3_CONTROL, {5'h00, m[2:0]});
            rd(OFS_TIMER3_CONTROL, {5'h00, m[2:0]});
            lvl({1'b0, m == 3});
        end
        v = 8'($urandom);
        wr(OFS_TIMER3_CONTROL, 8'h0a);
        wr(OFS_TIMER3_PWIDTH, v);
        rd(OFS_TIMER3_PWIDTH, v);
        wr(OFS_TIMER3_CONTROL, 8'h02);
        wr(OFS_TIMER3_COMPARE, 8'h03);
        wr(OFS_TIMER3_CONTROL, 8'h68);
        wait_ovf(1'b0, 20, 1'b1);
        wr(OFS_TIMER3_CONTROL, 8'h60);
        wr(OFS_CLOCK_CONFIG, 8'hfe);
        rd(OFS_CLOCK_CONFIG, 8'h02);
        wr(OFS_TIMER3_CONTROL, 8'h68);
        wait_ovf(1'b0, 40, 1'b0);
        wr(OFS_TIMER3_CONTROL, 8'h60);
        wr(OFS_CLOCK_CONFIG, 8'h00);
        // The divider option turns select 000 into the slow clock over eight.
        wr(OFS_CLOCK_CONFIG, 8'h01);
        wr(OFS_TIMER3_CONTROL, 8'h08);
        wait_ovf(1'b0, 400, 1'b1);
        wr(OFS_TIMER3_CONTROL, 8'h00);
        wr(OFS_CLOCK_CONFIG, 8'h00);
        wr(OFS_TIMER3_CONTROL, 8'h63);
        p = 1'($urandom);
        wr(OFS_TIMER4_CONTROL, {p, 7'h0e});
        lvl(2'b11);
        check({7'h00, t4_run}, 8'h01);
        check({7'h00, t4_ff}, {7'h00, p});
        wr(OFS_TIMER4_PWIDTH, v);
        rd(OFS_TIMER4_PWIDTH, v);
        wr(OFS_TIMER4_COMPARE, 8'h55);
        rd(OFS_TIMER4_COMPARE, 8'h00);
        wait_ovf(1'b1, 600, 1'b1);
        wr(OFS_TIMER4_CONTROL, 8'h06);
        lvl(2'b01);
        check({7'h00, t4_run}, 8'h00);
        // Warm-up mode lets the fast clock count in low-speed operation.
        wr(OFS_CLOCK_CONFIG, 8'h02);
        wr(OFS_TIMER4_CONTROL, 8'h0d);
        wait_ovf(1'b0, 300, 1'b1);
        wr(OFS_TIMER4_CONTROL, 8'h05);
        wr(OFS_CLOCK_CONFIG, 8'h00);
        repeat (2) @(posedge clk);
        stop_test();
    end
endmodule // timer3_control_and_cascade_bench
